// >>> hdl/usc_serial_ctrl.sv
// serial port control and status block with APB register access
// Operation
// - with frame checking on, a bad stop bit sets the framing-error flag.
// - framing-error flag stays set; only software clear or reset clears it.
// - bit 7 is framing-error flag when frame-check select is one, else mode-select high.
// - multiprocessor enable filters addresses in modes 1 to 3; software keeps it clear in mode 0.
// - reception starts only while the receive-allow bit is one.
// - transmit-done sets after 8th bit in mode 0, at stop start otherwise.
// - serial control resets to zero and each bit is individually writable.
// - with frame checking on, receive-done rises at the stop bit.
// - with filtering, address frames set receive-done only on given or broadcast match.
// - given address compares slave address only where the mask holds ones.
// - broadcast address is address OR mask, zeros there are don't-care.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.svh"
module usc_serial_ctrl #(
  parameter logic [15:0] BAUD_DIV_RST = 16'h0010 // bit period for variable-rate modes
) (
  input wire logic i_clock, // system clock, 200 MHz
  input wire logic i_sys_rst, // async reset, active high
  input wire usc_pkg::usc_apb_req_t i_apb, // APB request from the master
  output usc_pkg::usc_apb_rsp_t o_apb, // APB answer
  output logic o_irq, // level interrupt, high while an unmasked event is pending
  output logic o_txd, // serial data out, or shift clock in mode 0
  input wire logic i_rxd, // receive pin level
  output logic o_rxd_out, // receive pin drive value in mode 0
  output logic o_rxd_oe_n // receive pin drive enable, low while driving
);
  import usc_pkg::*;

  typedef struct packed {
    logic [7:0] serial_ctrl_reg;
    logic framing_err_flag;
    logic [7:0] slave_addr_reg;
    logic [7:0] slave_mask_reg;
    logic [1:0] power_ctrl_reg;
    logic [15:0] baud_div;
    logic x2_speed;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [7:0] tx_byte;
    logic tx_start;
    logic [7:0] rx_buf;
    logic rb8_pend;
    logic [2:0] rx_sync;
    logic rx_line;
    logic irq;
    usc_apb_rsp_t apb;
  } usc_main_st_t;

  localparam usc_main_st_t MAIN_RST = '{serial_ctrl_reg: `USC_SCTRL_RST,
    baud_div: BAUD_DIV_RST, rx_sync: 3'h7, rx_line: 1'b1, default: '0};

  // address decode shared by reads and writes
  function automatic usc_reg_t usc_decode(input logic [11:0] addr);
    usc_reg_t r;
    r = USC_REG_NONE;
    if (addr[11:10] == 2'h0 && addr[1:0] == 2'h0) begin
      case (addr[9:2])
        `USC_IDX_PCTRL: r = USC_REG_PCTRL;
        `USC_IDX_SCTRL: r = USC_REG_SCTRL;
        `USC_IDX_SLAVE_ADDR_REG: r = USC_REG_SLAVE_ADDR_REG;
        `USC_IDX_SMASK: r = USC_REG_SMASK;
        `USC_IDX_TXDATA: r = USC_REG_TXDATA;
        `USC_IDX_RXDATA: r = USC_REG_RXDATA;
        `USC_IDX_BAUD: r = USC_REG_BAUD;
        `USC_IDX_ISTAT: r = USC_REG_ISTAT;
        `USC_IDX_IMASK: r = USC_REG_IMASK;
        `USC_IDX_BITWR: r = USC_REG_BITWR;
        default: r = USC_REG_NONE;
      endcase
    end
    return r;
  endfunction

  // given address: compare only where the mask is one
  function automatic logic usc_given_hit(input logic [7:0] a, input logic [7:0] sa,
                                         input logic [7:0] sm);
    return ((a ^ sa) & sm) == 8'h00;
  endfunction

  // broadcast address: ones of address OR mask must be present
  function automatic logic usc_bcast_hit(input logic [7:0] a, input logic [7:0] sa,
                                         input logic [7:0] sm);
    logic [7:0] b;
    b = sa | sm;
    return ((a ^ b) & b) == 8'h00;
  endfunction

  usc_main_st_t s;
  usc_main_st_t n;
  usc_mode_t mode;
  usc_reg_t rsel;
  usc_eng_cfg_t cfg;
  usc_eng_ev_t ev;
  logic tx_busy;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic fcs;
  logic mp;
  logic addr_ok;
  logic take;
  logic rb8_val;
  logic setup;
  logic acc_wr;
  logic wr_sctrl;
  logic [7:0] sctrl_rd;
  logic [7:0] wval;
  logic [31:0] rdata;
  logic [15:0] bit_cycles;

  always_comb begin
    mode = usc_mode_t'({s.serial_ctrl_reg[`USC_SC_MODE_HI], s.serial_ctrl_reg[`USC_SC_MODE_LO]});
    fcs = s.power_ctrl_reg[`USC_PC_FCS];
    // bit 7 shows the framing-error flag only under frame-check select
    sctrl_rd = s.serial_ctrl_reg;
    if (fcs) sctrl_rd[`USC_SC_MODE_HI] = s.framing_err_flag;
    // bit period in system clocks for the selected mode
    case (mode)
      USC_MODE_SHIFT: bit_cycles = s.x2_speed ? `USC_DIV_M0_X2 : `USC_DIV_M0;
      USC_MODE_9FIX: bit_cycles = s.power_ctrl_reg[`USC_PC_DBL] ? `USC_DIV_M2_DBL : `USC_DIV_M2;
      default: bit_cycles = (s.baud_div == 16'h0000) ? 16'h0001 : s.baud_div;
    endcase
    cfg.mode = mode;
    cfg.bit_cycles = bit_cycles;
    cfg.rx_allow = s.serial_ctrl_reg[`USC_SC_RALLOW];
    cfg.rx_go = !s.serial_ctrl_reg[`USC_SC_RXDONE];
    // filtering has no effect in the shift-register mode
    mp = s.serial_ctrl_reg[`USC_SC_MP] && mode != USC_MODE_SHIFT;
    addr_ok = usc_given_hit(rx_byte, s.slave_addr_reg, s.slave_mask_reg) ||
              usc_bcast_hit(rx_byte, s.slave_addr_reg, s.slave_mask_reg);
    rsel = usc_decode(i_apb.paddr);
    rdata = 32'h0000_0000;
    case (rsel)
      USC_REG_PCTRL: begin
        rdata[`USC_PC_HI_DBL] = s.power_ctrl_reg[`USC_PC_DBL];
        rdata[`USC_PC_HI_FCS] = s.power_ctrl_reg[`USC_PC_FCS];
      end
      USC_REG_SCTRL: rdata[7:0] = sctrl_rd;
      USC_REG_SLAVE_ADDR_REG: rdata[7:0] = s.slave_addr_reg;
      USC_REG_SMASK: rdata[7:0] = s.slave_mask_reg;
      USC_REG_TXDATA: rdata[7:0] = s.tx_byte;
      USC_REG_RXDATA: rdata[7:0] = s.rx_buf;
      USC_REG_BAUD: rdata[16:0] = {s.x2_speed, s.baud_div};
      USC_REG_ISTAT: rdata[2:0] = s.int_stat;
      USC_REG_IMASK: rdata[2:0] = s.int_mask;
      USC_REG_BITWR: rdata[7:0] = sctrl_rd;
      default: rdata = 32'h0000_0000;
    endcase

    n = s;
    n.tx_start = 1'b0;
    // zero-wait APB: ready is raised for the access cycle after each setup
    setup = i_apb.psel && !i_apb.penable;
    n.apb.pready = setup;
    if (setup) begin
      n.apb.prdata = rdata;
      n.apb.pslverr = rsel == USC_REG_NONE;
    end
    acc_wr = i_apb.psel && i_apb.penable && s.apb.pready && i_apb.pwrite;

    // software writes first, hardware sets afterwards so a set is never lost
    wr_sctrl = 1'b0;
    wval = i_apb.pwdata[7:0];
    if (acc_wr) begin
      case (rsel)
        USC_REG_PCTRL: begin
          n.power_ctrl_reg[`USC_PC_DBL] = i_apb.pwdata[`USC_PC_HI_DBL];
          n.power_ctrl_reg[`USC_PC_FCS] = i_apb.pwdata[`USC_PC_HI_FCS];
        end
        USC_REG_SCTRL: wr_sctrl = 1'b1;
        USC_REG_BITWR: begin
          // single-bit write: other bits keep their value
          wr_sctrl = 1'b1;
          wval = sctrl_rd;
          wval[i_apb.pwdata[2:0]] = i_apb.pwdata[8];
        end
        USC_REG_SLAVE_ADDR_REG: n.slave_addr_reg = i_apb.pwdata[7:0];
        USC_REG_SMASK: n.slave_mask_reg = i_apb.pwdata[7:0];
        USC_REG_TXDATA: begin
          n.tx_byte = i_apb.pwdata[7:0];
          n.tx_start = !tx_busy;
        end
        USC_REG_BAUD: begin
          n.baud_div = i_apb.pwdata[15:0];
          n.x2_speed = i_apb.pwdata[`USC_BAUD_X2];
        end
        USC_REG_ISTAT: n.int_stat = s.int_stat & ~i_apb.pwdata[2:0];
        USC_REG_IMASK: n.int_mask = i_apb.pwdata[2:0];
        default: n.int_mask = s.int_mask;
      endcase
    end
    if (wr_sctrl) begin
      n.serial_ctrl_reg[6:0] = wval[6:0];
      if (fcs) begin
        n.framing_err_flag = wval[`USC_SC_MODE_HI];
      end else begin
        n.serial_ctrl_reg[`USC_SC_MODE_HI] = wval[`USC_SC_MODE_HI];
      end
    end

    // transmit done
    if (ev.tx_done) begin
      n.serial_ctrl_reg[`USC_SC_TXDONE] = 1'b1;
      n.int_stat[`USC_IRQ_TX] = 1'b1;
    end

    // receive acceptance per mode
    take = 1'b0;
    rb8_val = s.serial_ctrl_reg[`USC_SC_RX9];
    case (mode)
      USC_MODE_SHIFT: take = ev.rx_data;
      USC_MODE_8VAR: begin
        if (mp || fcs) begin
          // stop bit stands in for the ninth bit under filtering
          take = ev.rx_stop && (!mp || (ev.stop_bit && addr_ok));
          rb8_val = ev.stop_bit;
        end else begin
          take = ev.rx_data;
        end
      end
      default: begin
        take = (!mp || (rx_ninth && addr_ok)) &&
               (fcs ? ev.rx_stop : ev.rx_data);
        rb8_val = rx_ninth;
      end
    endcase
    if (take && !s.serial_ctrl_reg[`USC_SC_RXDONE]) begin
      n.rx_buf = rx_byte;
      if (mode != USC_MODE_SHIFT) n.serial_ctrl_reg[`USC_SC_RX9] = rb8_val;
      n.serial_ctrl_reg[`USC_SC_RXDONE] = 1'b1;
      n.int_stat[`USC_IRQ_RX] = 1'b1;
      // plain mode 1 raises done before the stop bit; its level follows
      n.rb8_pend = mode == USC_MODE_8VAR && !mp && !fcs;
    end else if (s.rb8_pend && ev.rx_stop) begin
      n.serial_ctrl_reg[`USC_SC_RX9] = ev.stop_bit;
      n.rb8_pend = 1'b0;
    end

    // framing error on a bad stop bit, sticky
    if (ev.rx_stop && mode != USC_MODE_SHIFT && fcs && !ev.stop_bit) begin
      n.framing_err_flag = 1'b1;
      n.int_stat[`USC_IRQ_FE] = 1'b1;
    end

    // receive pin: first stage feeds only the second
    n.rx_sync = {s.rx_sync[1:0], i_rxd};
    if (s.rx_sync[1] == s.rx_sync[2]) n.rx_line = s.rx_sync[2];

    n.irq = (s.int_stat & s.int_mask) != 3'h0;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= MAIN_RST;
    end else begin
      s <= n;
    end
  end

  usc_engine u_engine (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_cfg(cfg),
    .i_tx_start(s.tx_start),
    .i_tx_byte(s.tx_byte),
    .i_tx_ninth(s.serial_ctrl_reg[`USC_SC_TX9]),
    .i_rx_line(s.rx_line),
    .o_txd(o_txd),
    .o_rxd_out(o_rxd_out),
    .o_rxd_oe_n(o_rxd_oe_n),
    .o_tx_busy(tx_busy),
    .o_ev(ev),
    .o_rx_byte(rx_byte),
    .o_rx_ninth(rx_ninth)
  );

  assign o_apb = s.apb;
  assign o_irq = s.irq;
endmodule
`default_nettype wire

// >>> hdl/usc_consts.svh
// register indices, field positions, reset values and rate divisors of the serial control block
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH

// register indices; byte address is four times the index
`define USC_IDX_PCTRL 8'h87
`define USC_IDX_SCTRL 8'h98
`define USC_IDX_SLAVE_ADDR_REG 8'hA9
`define USC_IDX_SMASK 8'hB9
`define USC_IDX_TXDATA 8'hC0
`define USC_IDX_RXDATA 8'hC1
`define USC_IDX_BAUD 8'hC2
`define USC_IDX_ISTAT 8'hC3
`define USC_IDX_IMASK 8'hC4
`define USC_IDX_BITWR 8'hC5

// serial control bit positions
`define USC_SC_MODE_HI 7
`define USC_SC_MODE_LO 6
`define USC_SC_MP 5
`define USC_SC_RALLOW 4
`define USC_SC_TX9 3
`define USC_SC_RX9 2
`define USC_SC_TXDONE 1
`define USC_SC_RXDONE 0
`define USC_SCTRL_RST 8'h00

// power control bits kept here
`define USC_PC_DBL 1
`define USC_PC_FCS 0
`define USC_PC_HI_DBL 7
`define USC_PC_HI_FCS 6

// baud config fields
`define USC_BAUD_X2 16

// interrupt status bits
`define USC_IRQ_TX 0
`define USC_IRQ_RX 1
`define USC_IRQ_FE 2

// clock cycles per bit for the fixed-rate modes
`define USC_DIV_M0 16'h000C
`define USC_DIV_M0_X2 16'h0006
`define USC_DIV_M2 16'h0040
`define USC_DIV_M2_DBL 16'h0020

// index of the last data bit in a frame
`define USC_LAST_BIT8 4'h7
`define USC_LAST_BIT9 4'h8

`endif

// >>> hdl/usc_pkg.sv
// types shared by the serial control block
package usc_pkg;
  typedef enum logic [1:0] {
    USC_MODE_SHIFT = 2'b00,
    USC_MODE_8VAR = 2'b01,
    USC_MODE_9FIX = 2'b10,
    USC_MODE_9VAR = 2'b11
  } usc_mode_t;
  typedef enum logic [3:0] {
    USC_TX_IDLE = 4'b0001,
    USC_TX_START = 4'b0010,
    USC_TX_DATA = 4'b0100,
    USC_TX_STOP = 4'b1000
  } usc_tx_st_t;
  typedef enum logic [3:0] {
    USC_RX_IDLE = 4'b0001,
    USC_RX_START = 4'b0010,
    USC_RX_DATA = 4'b0100,
    USC_RX_STOP = 4'b1000
  } usc_rx_st_t;
  typedef enum logic [3:0] {
    USC_REG_NONE = 4'h0,
    USC_REG_PCTRL = 4'h1,
    USC_REG_SCTRL = 4'h2,
    USC_REG_SLAVE_ADDR_REG = 4'h3,
    USC_REG_SMASK = 4'h4,
    USC_REG_TXDATA = 4'h5,
    USC_REG_RXDATA = 4'h6,
    USC_REG_BAUD = 4'h7,
    USC_REG_ISTAT = 4'h8,
    USC_REG_IMASK = 4'h9,
    USC_REG_BITWR = 4'hA
  } usc_reg_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } usc_apb_req_t;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } usc_apb_rsp_t;
  typedef struct packed {
    usc_mode_t mode;
    logic [15:0] bit_cycles;
    logic rx_allow;
    logic rx_go;
  } usc_eng_cfg_t;
  typedef struct packed {
    logic tx_done;
    logic rx_data;
    logic rx_stop;
    logic stop_bit;
  } usc_eng_ev_t;
endpackage

// >>> hdl/usc_engine.sv
// serial bit engine: asynchronous frames and shift-register transfers
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.svh"
module usc_engine (
  input wire logic i_clock, // system clock
  input wire logic i_sys_rst, // async reset, active high
  input wire usc_pkg::usc_eng_cfg_t i_cfg, // mode, bit period, receive gates
  input wire logic i_tx_start, // one-cycle load of a new frame
  input wire logic [7:0] i_tx_byte, // byte to send
  input wire logic i_tx_ninth, // ninth bit for 9-bit modes
  input wire logic i_rx_line, // filtered receive line
  output logic o_txd, // serial out, or shift clock in mode 0
  output logic o_rxd_out, // shift data out in mode 0
  output logic o_rxd_oe_n, // shift data enable, low while driving
  output logic o_tx_busy, // transmit frame in progress
  output usc_pkg::usc_eng_ev_t o_ev, // one-cycle events
  output logic [7:0] o_rx_byte, // last received byte
  output logic o_rx_ninth // last received ninth bit
);
  import usc_pkg::*;

  typedef struct packed {
    usc_tx_st_t tx_st;
    usc_rx_st_t rx_st;
    logic [15:0] tcnt;
    logic [15:0] rcnt;
    logic [3:0] tbit;
    logic [3:0] rbit;
    logic [8:0] tsh;
    logic [8:0] rsh;
    logic txd;
    logic rxd_out;
    logic rxd_oe_n;
    usc_eng_ev_t ev;
    logic [7:0] rx_byte;
    logic rx_ninth;
  } usc_eng_st_t;

  localparam usc_eng_st_t ENG_RST = '{tx_st: USC_TX_IDLE, rx_st: USC_RX_IDLE,
    txd: 1'b1, rxd_oe_n: 1'b1, default: '0};

  usc_eng_st_t s;
  usc_eng_st_t n;
  logic [15:0] half;
  logic [15:0] last;
  logic mode0;
  logic nine;
  logic tend;
  logic rend;
  logic [8:0] rv;
  logic [3:0] lastbit;

  always_comb begin
    half = {1'b0, i_cfg.bit_cycles[15:1]};
    last = i_cfg.bit_cycles - 16'h0001;
    mode0 = i_cfg.mode == USC_MODE_SHIFT;
    nine = i_cfg.mode[1];
    lastbit = nine ? `USC_LAST_BIT9 : `USC_LAST_BIT8;
    // a bit period shortened mid-frame ends the bit at once instead of waiting for wrap
    tend = s.tcnt >= last;
    rend = s.rcnt >= last;
    rv = {i_rx_line, s.rsh[8:1]};
    n = s;
    n.ev = '0;
    case (s.tx_st)
      USC_TX_IDLE: begin
        if (i_tx_start) begin
          n.tsh = {i_tx_ninth, i_tx_byte};
          n.tcnt = '0;
          n.tbit = '0;
          n.txd = 1'b0;
          if (mode0) begin
            n.tx_st = USC_TX_DATA;
            n.rxd_oe_n = 1'b0;
            n.rxd_out = i_tx_byte[0];
          end else begin
            n.tx_st = USC_TX_START;
          end
        end
      end
      USC_TX_START: begin
        n.tcnt = s.tcnt + 16'h0001;
        if (tend) begin
          n.tcnt = '0;
          n.tx_st = USC_TX_DATA;
          n.txd = s.tsh[0];
        end
      end
      USC_TX_DATA: begin
        n.tcnt = s.tcnt + 16'h0001;
        // shift clock: low first half of the bit, high second half
        if (mode0) n.txd = s.tcnt >= half;
        if (tend) begin
          n.tcnt = '0;
          n.tbit = s.tbit + 4'h1;
          n.tsh = {1'b1, s.tsh[8:1]};
          if (mode0) begin
            n.rxd_out = s.tsh[1];
            if (s.tbit == `USC_LAST_BIT8) begin
              n.tx_st = USC_TX_IDLE;
              n.ev.tx_done = 1'b1;
              n.rxd_oe_n = 1'b1;
              n.txd = 1'b1;
            end
          end else if (s.tbit == lastbit) begin
            n.tx_st = USC_TX_STOP;
            n.txd = 1'b1;
            n.ev.tx_done = 1'b1;
          end else begin
            n.txd = s.tsh[1];
          end
        end
      end
      USC_TX_STOP: begin
        n.tcnt = s.tcnt + 16'h0001;
        if (tend) n.tx_st = USC_TX_IDLE;
      end
      default: n.tx_st = USC_TX_IDLE;
    endcase
    case (s.rx_st)
      USC_RX_IDLE: begin
        n.rcnt = '0;
        n.rbit = '0;
        if (i_cfg.rx_allow) begin
          if (mode0) begin
            if (i_cfg.rx_go && s.tx_st == USC_TX_IDLE && !i_tx_start) begin
              n.rx_st = USC_RX_DATA;
              n.txd = 1'b0;
            end
          end else if (!i_rx_line) begin
            n.rx_st = USC_RX_START;
          end
        end
      end
      USC_RX_START: begin
        n.rcnt = s.rcnt + 16'h0001;
        // recheck the start bit at its middle to reject glitches
        if (s.rcnt == half) begin
          n.rcnt = '0;
          n.rx_st = i_rx_line ? USC_RX_IDLE : USC_RX_DATA;
        end
      end
      USC_RX_DATA: begin
        n.rcnt = s.rcnt + 16'h0001;
        if (mode0) n.txd = s.rcnt >= half;
        if (rend) begin
          n.rcnt = '0;
          n.rbit = s.rbit + 4'h1;
          n.rsh = rv;
          if (mode0 && s.rbit == `USC_LAST_BIT8) begin
            n.rx_st = USC_RX_IDLE;
            n.txd = 1'b1;
            n.ev.rx_data = 1'b1;
            n.rx_byte = rv[8:1];
          end else if (!mode0 && s.rbit == lastbit) begin
            n.rx_st = USC_RX_STOP;
            n.ev.rx_data = 1'b1;
            n.rx_byte = nine ? rv[7:0] : rv[8:1];
            if (nine) n.rx_ninth = rv[8];
          end
        end
      end
      USC_RX_STOP: begin
        n.rcnt = s.rcnt + 16'h0001;
        if (rend) begin
          n.rx_st = USC_RX_IDLE;
          n.ev.rx_stop = 1'b1;
          n.ev.stop_bit = i_rx_line;
        end
      end
      default: n.rx_st = USC_RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= ENG_RST;
    end else begin
      s <= n;
    end
  end

  assign o_txd = s.txd;
  assign o_rxd_out = s.rxd_out;
  assign o_rxd_oe_n = s.rxd_oe_n;
  assign o_tx_busy = s.tx_st != USC_TX_IDLE;
  assign o_ev = s.ev;
  assign o_rx_byte = s.rx_byte;
  assign o_rx_ninth = s.rx_ninth;
endmodule
`default_nettype wire

// >>> bench/usc_chk.sv
// port-level checks of the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.svh"
module usc_chk #(
  parameter logic [15:0] BAUD_DIV_RST = 16'h0010 // bit period for variable-rate modes
) (
  input wire logic i_clock, // system clock
  input wire logic i_sys_rst, // async reset, active high
  input wire usc_pkg::usc_apb_req_t i_apb, // APB request
  input wire usc_pkg::usc_apb_rsp_t o_apb, // APB answer
  input wire logic o_irq, // level interrupt
  input wire logic o_txd, // serial out
  input wire logic i_rxd, // receive pin level
  input wire logic o_rxd_out, // pin drive value
  input wire logic o_rxd_oe_n // pin drive enable, low while driving
);
  import usc_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_wr(logic [7:0] idx, logic [31:0] d);
    i_apb.psel && i_apb.penable && i_apb.pwrite && o_apb.pready &&
      i_apb.paddr == {2'b00, idx, 2'b00} && i_apb.pwdata == d;
  endsequence
  reset_idle_a: assert property ($fell(i_sys_rst) |-> o_txd && o_rxd_oe_n && !o_irq && !o_rxd_out)
    else $error("outputs not idle after reset");
  setup_ready_a: assert property (s_setup |=> o_apb.pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (o_apb.pready |-> $past(i_apb.psel && !i_apb.penable))
    else $error("ready without setup");
  bad_addr_a: assert property (s_setup ##0 (i_apb.paddr[1:0] != 2'h0 ||
    i_apb.paddr[11:10] != 2'h0) |=> o_apb.pslverr && o_apb.prdata == 32'h0)
    else $error("bad address not refused");
  good_read_a: assert property (s_setup ##0 i_apb.paddr == {2'b00, `USC_IDX_SCTRL, 2'b00}
    |=> !o_apb.pslverr && o_apb.prdata[31:8] == 24'h0)
    else $error("control read malformed");
  rdata_hold_a: assert property (o_apb.pready |=> $stable(o_apb.prdata))
    else $error("read data moved");
  mask_off_a: assert property (s_wr(`USC_IDX_IMASK, 32'h0) |-> ##2 !o_irq)
    else $error("masked interrupt still high");
  stat_clr_a: assert property (s_wr(`USC_IDX_ISTAT, 32'h7) |-> ##2 !o_irq)
    else $error("cleared interrupt still high");
endmodule
bind usc_serial_ctrl usc_chk #(.BAUD_DIV_RST(BAUD_DIV_RST)) u_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_apb(i_apb), .o_apb(o_apb), .o_irq(o_irq), .o_txd(o_txd),
  .i_rxd(i_rxd), .o_rxd_out(o_rxd_out), .o_rxd_oe_n(o_rxd_oe_n));
`default_nettype wire

// >>> bench/usc_peer.sv
// remote serial node that sends frames on the receive line
`timescale 1ns/1ps
`default_nettype none
module usc_peer #(
  parameter int BIT = 16 // cycles per bit, same as baud config
) (
  input wire logic i_clock, // system clock
  output logic o_line // line to the block, idle high like a pull-up
);
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic nine, input logic n9, input logic stop);
    logic [10:0] f;
    f = n9 ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (n9 ? 11 : 10); i++) begin
      o_line <= f[i];
      repeat (BIT) @(posedge i_clock);
    end
    o_line <= 1'b1;
    repeat (2 * BIT) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_uart_serial_control_status.sv
// testbench of the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.svh"
module tb_uart_serial_control_status;
  import usc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  usc_apb_req_t req = '0;
  usc_apb_rsp_t rsp;
  logic irq;
  logic txd;
  logic rxo;
  logic rxd_oe_n;
  logic pl;
  wire logic rxd;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] q;
  assign rxd = rxd_oe_n ? pl : rxo;
  always #2.5 clk = ~clk;
  usc_serial_ctrl #(.BAUD_DIV_RST(16'h0004)) uut (.i_clock(clk), .i_sys_rst(rst),
    .i_apb(req), .o_apb(rsp), .o_irq(irq), .o_txd(txd), .i_rxd(rxd), .o_rxd_out(rxo),
    .o_rxd_oe_n(rxd_oe_n));
  usc_peer peer (.i_clock(clk), .o_line(pl));
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, ad(i), d);
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, ad(i), 32'h0);
    chk(q & m, e);
  endtask
  task automatic t_reset();
    rc(`USC_IDX_SCTRL, 32'hFF, 32'h00);
    apb(1'b0, 12'h261, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 12'h660, 32'hFF);
    rc(`USC_IDX_SCTRL, 32'hFF, 32'h00);
    wr(`USC_IDX_BITWR, 32'h103);
    rc(`USC_IDX_SCTRL, 32'hFF, 32'h08);
    wr(`USC_IDX_BITWR, 32'h003);
    rc(`USC_IDX_SCTRL, 32'hFF, 32'h00);
  endtask
  task automatic t_tx();
    logic [7:0] s;
    wr(`USC_IDX_BAUD, 32'h10);
    wr(`USC_IDX_IMASK, 32'h1);
    for (int m = 0; m < 4; m++) begin
      s = {m[1:0], 6'h00};
      wr(`USC_IDX_SCTRL, {24'h0, s});
      wr(`USC_IDX_TXDATA, 32'h25);
      if (m == 0) begin
        repeat (2) @(posedge clk);
        chk({29'h0, txd, rxd_oe_n, rxo}, 32'h1);
      end
      while (irq !== 1'b1) @(posedge clk);
      chk({30'h0, txd, rxd_oe_n}, 32'h3);
      rc(`USC_IDX_SCTRL, 32'hFF, {24'h0, s | 8'h02});
      wr(`USC_IDX_SCTRL, {24'h0, s});
      wr(`USC_IDX_ISTAT, 32'h7);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rc(`USC_IDX_SCTRL, 32'hFF, {24'h0, s});
    end
    wr(`USC_IDX_IMASK, 32'h0);
  endtask
  task automatic t_rx();
    wr(`USC_IDX_SCTRL, 32'h40);
    peer.send(8'h5A, 1'b0, 1'b0, 1'b1);
    rc(`USC_IDX_SCTRL, 32'hFF, 32'h40);
    wr(`USC_IDX_SCTRL, 32'h50);
    peer.send(8'h5A, 1'b0, 1'b0, 1'b1);
    rc(`USC_IDX_RXDATA, 32'hFF, 32'h5A);
    rc(`USC_IDX_SCTRL, 32'hFF, 32'h55);
  endtask
  task automatic t_fe();
    wr(`USC_IDX_PCTRL, 32'h40);
    wr(`USC_IDX_SCTRL, 32'h50);
    peer.send(8'h33, 1'b0, 1'b0, 1'b0);
    rc(`USC_IDX_SCTRL, 32'h80, 32'h80);
    wr(`USC_IDX_SCTRL, 32'hD0);
    peer.send(8'h11, 1'b0, 1'b0, 1'b1);
    rc(`USC_IDX_SCTRL, 32'h81, 32'h81);
    wr(`USC_IDX_PCTRL, 32'h00);
    rc(`USC_IDX_SCTRL, 32'h80, 32'h00);
    wr(`USC_IDX_PCTRL, 32'h40);
    rc(`USC_IDX_SCTRL, 32'h80, 32'h80);
    wr(`USC_IDX_SCTRL, 32'h50);
    rc(`USC_IDX_SCTRL, 32'h80, 32'h00);
    wr(`USC_IDX_PCTRL, 32'h00);
  endtask
  task automatic t_mp();
    wr(`USC_IDX_SLAVE_ADDR_REG, 32'h56);
    wr(`USC_IDX_SMASK, 32'hFC);
    wr(`USC_IDX_SCTRL, 32'hF0);
    peer.send(8'h57, 1'b0, 1'b1, 1'b1);
    rc(`USC_IDX_SCTRL, 32'h01, 32'h00);
    peer.send(8'h57, 1'b1, 1'b1, 1'b1);
    rc(`USC_IDX_SCTRL, 32'h05, 32'h05);
    rc(`USC_IDX_RXDATA, 32'hFF, 32'h57);
    wr(`USC_IDX_SCTRL, 32'hF0);
    peer.send(8'h00, 1'b1, 1'b1, 1'b1);
    rc(`USC_IDX_SCTRL, 32'h01, 32'h00);
    peer.send(8'hFE, 1'b1, 1'b1, 1'b1);
    rc(`USC_IDX_SCTRL, 32'h01, 32'h01);
    wr(`USC_IDX_SCTRL, 32'h70);
    peer.send(8'h57, 1'b0, 1'b0, 1'b0);
    rc(`USC_IDX_SCTRL, 32'h01, 32'h00);
    peer.send(8'h57, 1'b0, 1'b0, 1'b1);
    rc(`USC_IDX_SCTRL, 32'h05, 32'h05);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_fe();
    t_mp();
    print_verdict();
  end
endmodule
`default_nettype wire
